// ### design/loader_cfg.svh
// constants of the wide passive load link: offsets, field positions, timing counts
// assumes a 200 MHz system clock on both ends of the link
//
// Functional notes
// - load clocks per word follow width and options
// - host runs load clock at ratio times word rate
// - host stops clock only ratio minus one later
// - 16-bit uses 15..0, 8-bit uses 7..0
// - after configuration load clock is ignored, held defined
// - user mode: request, status, done high; request restarts
// - status held low for power-on delay
// - done low from power-up until load finishes
// - done rises only after whole error-free image
// - two falling load-clock edges after done start init
// - init-finished output low once its option loads
// - request fall pulls done and status low quickly
// - host holds request low at least 2 us
// - status low pulse between 268 and 1506 us
// - status released after request rises, unless held
// - host waits 2 us after status rises
// - load clock at most 125 or 100 MHz
// - internal oscillator init takes 175 to 437 us
// - user clock: 4 load periods, then 8576 periods
// - ratio one with both options off, and for 8-bit with security alone
// - paused load clock is low; data ready before restart
`ifndef LOADER_CFG_SVH
`define LOADER_CFG_SVH

`define CLK_MHZ 200
`define DATA_W 32
`define FIFO_DEPTH 16

`define T_CFG_US 2
`define CYC_CFG (`T_CFG_US * `CLK_MHZ)
`define T_ST2CK_US 2
`define CYC_ST2CK (`T_ST2CK_US * `CLK_MHZ)
`define T_STATUS_MIN_US 268
`define CYC_STATUS_MIN (`T_STATUS_MIN_US * `CLK_MHZ)
`define T_POR_US 100
`define CYC_POR (`T_POR_US * `CLK_MHZ)
`define T_CD2UM_MIN_US 175
`define CYC_CD2UM (`T_CD2UM_MIN_US * `CLK_MHZ)
`define T_LOADCLK_MAX_NS 10
`define CD2CU_PERIODS 4
`define CYC_CD2CU ((`CD2CU_PERIODS * `T_LOADCLK_MAX_NS * `CLK_MHZ + 999) / 1000)
`define USER_INIT_PERIODS 8576

// host divider: 4 + 4 cycles is 40 ns, 25 MHz, below both ceilings
`define LOAD_HALF_CYC 4
`define USER_CLK_HALF_CYC 4

// header word: option bit at the bottom, payload word count above it
`define HDR_INIT_OPT_BIT 0
`define HDR_COUNT_LSB 1

`endif

// ### design/loader_pkg.sv
// types and shared decoding of the wide passive load link
// assumes nothing beyond the constants header
package loader_pkg;

    typedef enum logic [1:0] {
        WIDTH_8 = 2'h0,
        WIDTH_16 = 2'h1,
        WIDTH_32 = 2'h2
    } bus_width_t;

    // load clocks per word
    function automatic logic [3:0] word_ratio(input bus_width_t w, input logic decomp,
                                              input logic secure);
        logic [3:0] r;
        r = 4'h1;
        unique case (w)
            WIDTH_8: r = decomp ? 4'h2 : 4'h1;
            WIDTH_16: r = decomp ? 4'h4 : (secure ? 4'h2 : 4'h1);
            default: r = decomp ? 4'h8 : (secure ? 4'h4 : 4'h1);
        endcase
        return r;
    endfunction

    // only the lanes of the chosen width carry data
    function automatic logic [31:0] lane_mask(input bus_width_t w, input logic [31:0] d);
        logic [31:0] m;
        m = d;
        unique case (w)
            WIDTH_8: m = {24'h000000, d[7:0]};
            WIDTH_16: m = {16'h0000, d[15:0]};
            default: m = d;
        endcase
        return m;
    endfunction

endpackage

// ### design/load_link_if.sv
// pins of the wide passive load link between host and device
// assumes status and init-finished are pulled up and only ever driven low
`timescale 1ns/100ps
`default_nettype none
interface load_link_if;
    logic config_req_n;
    logic status_oe_dev;
    logic status_oe_host;
    logic status_n;
    logic done;
    logic init_done_oe;
    logic init_done_n;
    logic load_clock;
    logic user_init_clock;
    logic [31:0] data_drv;
    logic data_oe;
    logic [31:0] data;

    assign status_n = !(status_oe_dev || status_oe_host);
    assign init_done_n = !init_done_oe;
    assign data = data_oe ? data_drv : 32'h00000000;

    modport device(
        input config_req_n, status_n, load_clock, user_init_clock, data,
        output status_oe_dev, done, init_done_oe
    );
    modport host(
        output config_req_n, status_oe_host, load_clock, user_init_clock, data_drv, data_oe,
        input status_n, done, init_done_n
    );
endinterface
`default_nettype wire

// ### design/load_device.sv
// device end of the wide passive load link with its word fifo
// assumes the host keeps its side of the link; all pins reach clk through three flops
`timescale 1ns/100ps
`default_nettype none
`include "loader_cfg.svh"

module word_fifo #(
    parameter int WIDTH = `DATA_W,
    parameter int DEPTH = `FIFO_DEPTH
) (
    input wire logic clk, // system clock
    input wire logic reset, // synchronous, active high
    input wire logic [WIDTH-1:0] in_data, // word to store
    input wire logic in_valid, // store request
    output logic in_ready, // room for a word
    output logic [WIDTH-1:0] out_data, // oldest word
    output logic out_valid, // a word is held
    input wire logic out_ready // consumer takes the word
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
    } fifo_regs_t;

    fifo_regs_t r_reg, r_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push, pop;

    assign in_ready = r_reg.count != (AW+1)'(DEPTH);
    assign out_valid = r_reg.count != '0;
    assign out_data = mem[r_reg.rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        r_next = r_reg;
        if (push) begin
            r_next.wr_ptr = r_reg.wr_ptr + 1'b1;
        end
        if (pop) begin
            r_next.rd_ptr = r_reg.rd_ptr + 1'b1;
        end
        r_next.count = r_reg.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[r_reg.wr_ptr] <= in_data;
        end
    end
endmodule

module load_device #(
    parameter logic [31:0] POR_CYC = 32'(`CYC_POR),
    parameter logic [31:0] STATUS_MIN_CYC = 32'(`CYC_STATUS_MIN),
    parameter logic [31:0] INIT_CYC = 32'(`CYC_CD2UM),
    parameter logic [31:0] USER_PERIODS = 32'(`USER_INIT_PERIODS)
) (
    load_link_if.device lnk, // link pins
    input wire logic clk, // system clock
    input wire logic reset, // synchronous, active high
    input wire loader_pkg::bus_width_t width_sel, // bus width strap
    input wire logic decomp_en, // decompression on
    input wire logic secure_en, // design security on
    input wire logic user_clk_opt, // initialise from the user clock
    output logic [31:0] word_data, // received payload word
    output logic word_valid, // payload word waiting
    input wire logic word_ready, // payload word taken
    output logic user_mode, // device in user mode
    output logic init_opt // image enabled the init-finished pin
);
    typedef enum logic [7:0] {
        D_POR = 8'h01,
        D_CLEAR = 8'h02,
        D_LOAD = 8'h04,
        D_TRAIL = 8'h08,
        D_GATE = 8'h10,
        D_INIT = 8'h20,
        D_USER = 8'h40,
        D_FAULT = 8'h80
    } dev_state_t;

    typedef struct packed {
        dev_state_t state;
        logic [31:0] cnt;
        logic [2:0] req_s;
        logic [2:0] lc_s;
        logic [2:0] uc_s;
        logic [2:0] st_s;
        logic req_lvl;
        logic lc_lvl;
        logic uc_lvl;
        logic st_lvl;
        logic [31:0] d1;
        logic [31:0] d2;
        logic [31:0] d3;
        loader_pkg::bus_width_t width;
        logic [3:0] ratio;
        logic [3:0] phase;
        logic hdr_seen;
        logic [30:0] words_left;
        logic init_opt;
        logic user_clk;
        logic [1:0] falls;
        logic done;
        logic status_drv;
        logic initdone_drv;
    } dev_regs_t;

    dev_regs_t r_reg, r_next;
    logic push_valid, push_ready;
    logic [31:0] push_data;
    logic lc_rise, lc_fall, uc_rise, req_fall;

    // a change counts once the second and third flops agree
    function automatic logic settle(input logic [2:0] s, input logic lvl);
        return (s[1] == s[2]) ? s[2] : lvl;
    endfunction

    always_comb begin
        r_next = r_reg;
        push_valid = 1'b0;
        push_data = loader_pkg::lane_mask(r_reg.width, r_reg.d3);
        r_next.req_s = {r_reg.req_s[1:0], lnk.config_req_n};
        r_next.lc_s = {r_reg.lc_s[1:0], lnk.load_clock};
        r_next.uc_s = {r_reg.uc_s[1:0], lnk.user_init_clock};
        r_next.st_s = {r_reg.st_s[1:0], lnk.status_n};
        r_next.d1 = lnk.data;
        r_next.d2 = r_reg.d1;
        r_next.d3 = r_reg.d2;
        r_next.req_lvl = settle(r_reg.req_s, r_reg.req_lvl);
        r_next.lc_lvl = settle(r_reg.lc_s, r_reg.lc_lvl);
        r_next.uc_lvl = settle(r_reg.uc_s, r_reg.uc_lvl);
        r_next.st_lvl = settle(r_reg.st_s, r_reg.st_lvl);
        lc_rise = !r_reg.lc_lvl && r_next.lc_lvl;
        lc_fall = r_reg.lc_lvl && !r_next.lc_lvl;
        uc_rise = !r_reg.uc_lvl && r_next.uc_lvl;
        req_fall = r_reg.req_lvl && !r_next.req_lvl;
        r_next.cnt = (r_reg.cnt == 32'hffffffff) ? r_reg.cnt : r_reg.cnt + 32'h1;

        unique case (r_reg.state)
            D_POR: begin
                r_next.status_drv = 1'b1;
                r_next.done = 1'b0;
                if (r_reg.cnt >= POR_CYC - 32'h1) begin
                    r_next.state = D_CLEAR;
                    r_next.cnt = 32'h0;
                end
            end
            D_CLEAR: begin
                r_next.status_drv = 1'b1;
                r_next.done = 1'b0;
                r_next.initdone_drv = 1'b0;
                r_next.hdr_seen = 1'b0;
                r_next.phase = 4'h0;
                r_next.width = width_sel;
                r_next.user_clk = user_clk_opt;
                r_next.ratio = loader_pkg::word_ratio(width_sel, decomp_en, secure_en);
                // least pulse first, then release as soon as the request is high
                if (r_reg.req_lvl && r_reg.cnt >= STATUS_MIN_CYC - 32'h1) begin
                    r_next.status_drv = 1'b0;
                    r_next.state = D_LOAD;
                end
            end
            D_LOAD: begin
                // words are refused while status is still held low outside
                if (lc_rise && r_reg.st_lvl) begin
                    r_next.phase = (r_reg.phase + 4'h1 == r_reg.ratio) ? 4'h0
                                                                       : r_reg.phase + 4'h1;
                    if (r_reg.phase == 4'h0) begin
                        if (!r_reg.hdr_seen) begin
                            r_next.hdr_seen = 1'b1;
                            r_next.words_left = push_data[31:`HDR_COUNT_LSB];
                            r_next.init_opt = push_data[`HDR_INIT_OPT_BIT];
                            r_next.initdone_drv = push_data[`HDR_INIT_OPT_BIT];
                            if (push_data[31:`HDR_COUNT_LSB] == 31'h0) begin
                                r_next.done = 1'b1;
                                r_next.state = D_TRAIL;
                                r_next.falls = 2'h0;
                            end
                        end else if (!push_ready) begin
                            // overflow loses a word: report an error on status
                            r_next.status_drv = 1'b1;
                            r_next.state = D_FAULT;
                        end else begin
                            push_valid = 1'b1;
                            r_next.words_left = r_reg.words_left - 31'h1;
                            if (r_reg.words_left == 31'h1) begin
                                r_next.done = 1'b1;
                                r_next.state = D_TRAIL;
                                r_next.falls = 2'h0;
                            end
                        end
                    end
                end
            end
            D_TRAIL: begin
                if (lc_fall) begin
                    r_next.falls = r_reg.falls + 2'h1;
                    if (r_reg.falls == 2'h1) begin
                        r_next.state = r_reg.user_clk ? D_GATE : D_INIT;
                        r_next.cnt = 32'h0;
                    end
                end
            end
            D_GATE: begin
                if (r_reg.cnt >= 32'(`CYC_CD2CU) - 32'h1) begin
                    r_next.state = D_INIT;
                    r_next.cnt = 32'h0;
                end
            end
            D_INIT: begin
                if (r_reg.user_clk) begin
                    r_next.cnt = uc_rise ? r_reg.cnt + 32'h1 : r_reg.cnt;
                    if (uc_rise && r_reg.cnt >= USER_PERIODS - 32'h1) begin
                        r_next.state = D_USER;
                        r_next.initdone_drv = 1'b0;
                    end
                end else if (r_reg.cnt >= INIT_CYC - 32'h1) begin
                    r_next.state = D_USER;
                    r_next.initdone_drv = 1'b0;
                end
            end
            D_USER: begin
                r_next.status_drv = 1'b0;
            end
            D_FAULT: begin
                r_next.status_drv = 1'b1;
            end
        endcase

        // load clock activity matters only in the load and trail states
        if (req_fall && r_reg.state != D_POR) begin
            r_next.state = D_CLEAR;
            r_next.cnt = 32'h0;
            r_next.status_drv = 1'b1;
            r_next.done = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            r_reg <= '0;
            r_reg.state <= D_POR;
            r_reg.req_s <= 3'h7;
            r_reg.req_lvl <= 1'b1;
            r_reg.ratio <= 4'h1;
            r_reg.status_drv <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    word_fifo #(.WIDTH(`DATA_W), .DEPTH(`FIFO_DEPTH)) fifo_u (
        .clk(clk),
        .reset(reset),
        .in_data(push_data),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .out_data(word_data),
        .out_valid(word_valid),
        .out_ready(word_ready)
    );

    assign lnk.status_oe_dev = r_reg.status_drv;
    assign lnk.done = r_reg.done;
    assign lnk.init_done_oe = r_reg.initdone_drv;
    assign user_mode = r_reg.state == D_USER;
    assign init_opt = r_reg.init_opt;
endmodule
`default_nettype wire

// ### design/load_host.sv
// host end of the wide passive load link: drives request, load clock and data
// assumes the user supplies the image as header word then payload words
`timescale 1ns/100ps
`default_nettype none
`include "loader_cfg.svh"
module load_host (
    load_link_if.host lnk, // link pins
    input wire logic clk, // system clock
    input wire logic reset, // synchronous, active high
    input wire logic start, // pulse: begin a configuration
    input wire loader_pkg::bus_width_t width_sel, // bus width in use
    input wire logic decomp_en, // image is compressed
    input wire logic secure_en, // image is encrypted
    input wire logic hold_status, // hold status low from outside
    input wire logic [31:0] wr_data, // image word
    input wire logic wr_last, // final word of the image
    input wire logic wr_valid, // image word offered
    output logic wr_ready, // image word taken
    output logic busy, // configuration under way
    output logic fail // status fell during loading
);
    typedef enum logic [8:0] {
        H_IDLE = 9'h001,
        H_REQ = 9'h002,
        H_WAIT_ST = 9'h004,
        H_GAP = 9'h008,
        H_FETCH = 9'h010,
        H_HIGH = 9'h020,
        H_LOW = 9'h040,
        H_DONE_WAIT = 9'h080,
        H_END = 9'h100
    } host_state_t;

    typedef struct packed {
        host_state_t state;
        logic [15:0] cnt;
        logic [2:0] st_s;
        logic [2:0] cd_s;
        logic st_lvl;
        logic cd_lvl;
        logic req_n;
        logic lclk;
        logic uclk;
        logic [2:0] ucnt;
        logic [31:0] data;
        logic data_oe;
        loader_pkg::bus_width_t width;
        logic [3:0] ratio;
        logic [3:0] edges;
        logic last;
        logic trailer;
        logic busy;
        logic fail;
    } host_regs_t;

    host_regs_t r_reg, r_next;

    function automatic logic settle(input logic [2:0] s, input logic lvl);
        return (s[1] == s[2]) ? s[2] : lvl;
    endfunction

    always_comb begin
        r_next = r_reg;
        wr_ready = 1'b0;
        r_next.st_s = {r_reg.st_s[1:0], lnk.status_n};
        r_next.cd_s = {r_reg.cd_s[1:0], lnk.done};
        r_next.st_lvl = settle(r_reg.st_s, r_reg.st_lvl);
        r_next.cd_lvl = settle(r_reg.cd_s, r_reg.cd_lvl);
        r_next.cnt = r_reg.cnt + 16'h1;
        r_next.ucnt = r_reg.ucnt + 3'h1;
        if (r_reg.ucnt == 3'(`USER_CLK_HALF_CYC - 1)) begin
            r_next.ucnt = 3'h0;
            r_next.uclk = !r_reg.uclk;
        end

        unique case (r_reg.state)
            H_IDLE: begin
                r_next.lclk = 1'b0;
                if (start) begin
                    r_next.width = width_sel;
                    r_next.ratio = loader_pkg::word_ratio(width_sel, decomp_en, secure_en);
                    r_next.req_n = 1'b0;
                    r_next.cnt = 16'h0;
                    r_next.busy = 1'b1;
                    r_next.fail = 1'b0;
                    r_next.trailer = 1'b0;
                    r_next.state = H_REQ;
                end
            end
            H_REQ: begin
                if (r_reg.cnt >= 16'(`CYC_CFG - 1)) begin
                    r_next.req_n = 1'b1;
                    r_next.state = H_WAIT_ST;
                end
            end
            H_WAIT_ST: begin
                r_next.cnt = 16'h0;
                if (r_reg.st_lvl) begin
                    r_next.state = H_GAP;
                end
            end
            H_GAP: begin
                if (r_reg.cnt >= 16'(`CYC_ST2CK - 1)) begin
                    r_next.state = H_FETCH;
                end
            end
            H_FETCH: begin
                // no word offered: the load clock rests low
                wr_ready = 1'b1;
                if (wr_valid) begin
                    r_next.data = loader_pkg::lane_mask(r_reg.width, wr_data);
                    r_next.data_oe = 1'b1;
                    r_next.last = wr_last;
                    r_next.edges = r_reg.ratio;
                    r_next.cnt = 16'h0;
                    r_next.state = H_LOW;
                end
            end
            H_HIGH: begin
                if (r_reg.cnt >= 16'(`LOAD_HALF_CYC - 1)) begin
                    r_next.lclk = 1'b0;
                    r_next.cnt = 16'h0;
                    r_next.state = H_LOW;
                end
            end
            H_LOW: begin
                if (r_reg.cnt >= 16'(`LOAD_HALF_CYC - 1)) begin
                    r_next.cnt = 16'h0;
                    if (r_reg.edges != 4'h0) begin
                        r_next.lclk = 1'b1;
                        r_next.edges = r_reg.edges - 4'h1;
                        r_next.state = H_HIGH;
                    end else if (r_reg.trailer) begin
                        r_next.state = H_END;
                    end else if (r_reg.last) begin
                        // the ratio-minus-one spare edges are already sent
                        r_next.state = H_DONE_WAIT;
                    end else begin
                        r_next.state = H_FETCH;
                    end
                end
            end
            H_DONE_WAIT: begin
                if (r_reg.cd_lvl) begin
                    r_next.data_oe = 1'b0;
                    r_next.trailer = 1'b1;
                    r_next.edges = 4'h2;
                    r_next.cnt = 16'h0;
                    r_next.state = H_LOW;
                end
            end
            H_END: begin
                r_next.lclk = 1'b0;
                r_next.busy = 1'b0;
                r_next.state = H_IDLE;
            end
        endcase

        if (!r_reg.st_lvl && (r_reg.state == H_FETCH || r_reg.state == H_HIGH
                || r_reg.state == H_LOW || r_reg.state == H_DONE_WAIT)) begin
            r_next.fail = 1'b1;
            r_next.busy = 1'b0;
            r_next.data_oe = 1'b0;
            r_next.lclk = 1'b0;
            r_next.state = H_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            r_reg <= '0;
            r_reg.state <= H_IDLE;
            r_reg.req_n <= 1'b1;
            r_reg.ratio <= 4'h1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign lnk.config_req_n = r_reg.req_n;
    assign lnk.status_oe_host = hold_status;
    assign lnk.load_clock = r_reg.lclk;
    assign lnk.user_init_clock = r_reg.uclk;
    assign lnk.data_drv = r_reg.data;
    assign lnk.data_oe = r_reg.data_oe;
    assign busy = r_reg.busy;
    assign fail = r_reg.fail;
endmodule
`default_nettype wire

// ### verif/load_link_checker.sv
// timing relations on the load link pins
// assumes it sits beside the link interface with the device's shortened counts
`timescale 1ns/100ps
`default_nettype none
module load_link_checker #(parameter int STATUS_MIN = 50, parameter int INIT_CYC = 40) (
    input wire logic clk, // clock
    input wire logic reset, // sync reset
    input wire logic config_req_n, // request
    input wire logic status_n, // status
    input wire logic done, // loaded
    input wire logic init_done_n, // init pin
    input wire logic load_clock // load clock
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic [15:0] lo_reg, hi_reg, dn_reg;
    // saturating run lengths of status low, status high and done high
    always_ff @(posedge clk) begin
        lo_reg <= (reset || status_n) ? 16'h0 : lo_reg + 16'(lo_reg != 16'hffff);
        hi_reg <= (reset || !status_n) ? 16'h0 : hi_reg + 16'(hi_reg != 16'hffff);
        dn_reg <= (reset || !done) ? 16'h0 : dn_reg + 16'(dn_reg != 16'hffff);
    end
    sequence pulled_low;
        !done && !status_n;
    endsequence
    req_pull_low_a: assert property ($fell(config_req_n) |-> ##[1:120] pulled_low)
        else $error("request fall not answered");
    status_min_a: assert property ($rose(status_n) |-> lo_reg >= 16'(STATUS_MIN))
        else $error("status pulse short");
    status_rel_a: assert property ($rose(config_req_n) |-> ##[1:100] status_n)
        else $error("status not released");
    clk_wait_a: assert property ($rose(load_clock) |-> hi_reg >= 16'h190)
        else $error("load clock too early");
    clk_high_a: assert property ($rose(load_clock) |-> load_clock [*4])
        else $error("load clock high too short");
    user_pins_a: assert property (done && config_req_n |-> status_n)
        else $error("status low while loaded");
    init_low_a: assert property ($fell(init_done_n) |-> !done)
        else $error("init pin fell after load");
    init_rel_a: assert property ($rose(init_done_n) |-> done && dn_reg >= 16'(INIT_CYC))
        else $error("user mode too early");
endmodule
`default_nettype wire

// ### verif/tb.sv
// host and device joined by the load link, run through every width and option
// assumes shortened device counts and a 200 MHz clock
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk = 1'b0, reset = 1'b1, start = 1'b0, dc = 1'b0, sc = 1'b0, uc = 1'b0;
    logic hold = 1'b1, wr_last = 1'b0, wr_valid = 1'b0, rdy = 1'b1;
    logic lc_q = 1'b0;
    int n_rises = 0;
    loader_pkg::bus_width_t w = loader_pkg::WIDTH_8;
    logic [31:0] wr_data = 32'h0, word_data, exp_q[$];
    logic wr_ready, busy, fail, word_valid, user_mode, init_opt;
    int n_errors = 0, num_checks = 0;
    load_link_if i_load_link_if ();
    load_host i_load_host (.lnk(i_load_link_if.host), .clk(clk), .reset(reset), .start(start),
        .width_sel(w), .decomp_en(dc), .secure_en(sc), .hold_status(hold), .wr_data(wr_data),
        .wr_last(wr_last), .wr_valid(wr_valid), .wr_ready(wr_ready), .busy(busy), .fail(fail));
    load_device #(.POR_CYC(32'h14), .STATUS_MIN_CYC(32'h32), .INIT_CYC(32'h28),
        .USER_PERIODS(32'ha)) i_load_device (.lnk(i_load_link_if.device), .clk(clk),
        .reset(reset), .width_sel(w), .decomp_en(dc), .secure_en(sc), .user_clk_opt(uc),
        .word_data(word_data), .word_valid(word_valid), .word_ready(rdy),
        .user_mode(user_mode), .init_opt(init_opt));
    load_link_checker i_load_link_checker (.clk(clk),
        .reset(reset), .config_req_n(i_load_link_if.config_req_n),
        .status_n(i_load_link_if.status_n), .done(i_load_link_if.done),
        .init_done_n(i_load_link_if.init_done_n), .load_clock(i_load_link_if.load_clock));
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        num_checks++;
        if (got !== want) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    task automatic final_report();
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // valid stays up between words; the caller drops it after the last
    task automatic put(input logic [31:0] d, input logic last);
        wr_data <= d;
        wr_last <= last;
        wr_valid <= 1'b1;
        do @(posedge clk); while (wr_ready !== 1'b1);
    endtask
    // m picks width m/4, decompression m[1], security m[0]
    task automatic run(input int m, input int n, input logic opt, input logic stall);
        logic [31:0] msk;
        logic ovf;
        int r, r0;
        msk = (m < 4) ? 32'hff : ((m < 8) ? 32'hffff : 32'hffffffff);
        ovf = stall && n > 16;
        // load clocks per word for this width and option pair
        r = m[1] ? (2 << (m / 4)) : ((m[0] && m >= 4) ? (1 << (m / 4)) : 1);
        r0 = n_rises;
        w <= loader_pkg::bus_width_t'(m / 4);
        dc <= m[1];
        sc <= m[0];
        uc <= m[0] ^ m[2];
        rdy <= !stall;
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        put({n[30:0], opt}, n == 0);
        for (int i = 0; i < n; i++) begin
            put(32'hc3a59600 + 32'(i), i == n - 1);
            if (i < 16) exp_q.push_back((32'hc3a59600 + 32'(i)) & msk);
        end
        wr_valid <= 1'b0;
        for (int k = 0; k < 4000 && (user_mode !== 1'b1 || busy !== 1'b0) && fail !== 1'b1;
            k++) @(posedge clk);
        chk({busy, user_mode, i_load_link_if.done, i_load_link_if.status_n, fail},
            ovf ? 32'h1 : 32'he);
        if (!ovf) chk(32'(n_rises - r0), 32'((n + 1) * r + 2));
        if (!ovf) chk(init_opt, opt);
        if (!ovf) chk(i_load_link_if.init_done_n, 1'b1);
        rdy <= 1'b1;
        for (int k = 0; k < 200 && exp_q.size() > 0; k++) @(posedge clk);
        chk(32'(exp_q.size()), 32'h0);
    endtask
    always @(posedge clk) begin
        lc_q <= i_load_link_if.load_clock;
        if (i_load_link_if.load_clock === 1'b1 && lc_q === 1'b0) n_rises++;
        if (word_valid === 1'b1 && rdy === 1'b1) begin
            chk(word_data, exp_q.size() > 0 ? exp_q.pop_front() : 32'hbad0bad0);
        end
    end
    initial begin
        forever #2.5 clk = ~clk;
    end
    // status held low from outside past the device's own release
    initial begin
        repeat (450) @(posedge clk);
        hold <= 1'b0;
    end
    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        final_report();
    end
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        run(8, 17, 1'b0, 1'b1);
        for (int m = 0; m < 12; m++) begin
            run(m, (m == 5) ? 16 : 2, m[1], m == 5);
        end
        final_report();
    end
endmodule
`default_nettype wire
